// ==== design/dvfstc_pkg.sv ====
// constants and types for the operating-point transition controller
// Summary of operation
// R1: software register write starts operating-point change
// R2: faster target: raise voltage code, then relock
// R3: slower target: relock first, then voltage code
// R4: requests anytime; overlapping ones wait for completion
// R5: voltage code moves in paced single steps
// R6: core unavailable at most 10 us
// R7: bus not ready driven while core unavailable
// R8: no arbiter disable or cache flush needed
// R9: overheating moves to programmable thermal point
// R10: after fixed wait, cool die restores prior point
// R11: thermal down and up transitions raise event
// R12: data buffers enabled only by power input
// R13: address buffers follow priority agent request
// R14: termination off while pin driven low
// R15: power status asserted during deep sleep
// R16: six-bit push-pull supply voltage code
// R17: code 0 is 1.708 V, minus 16 mV
// R18: core clock multiplier set by operating point
// R19: deep sleep requested only from sleep state
// R20: one pending request, newest wins, busy visible
// R21: thermal down transition beats pending software request
package dvfstc_pkg;
	localparam int          CLK_PERIOD_NS  = 25;        // bus clock, 40 MHz
	localparam int          STEP_TIME_NS   = 1000;      // least time per voltage code step
	localparam int          STEP_CYC       = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          LOCK_TIME_NS   = 10000;     // longest core unavailability
	localparam int          LOCK_CYC       = LOCK_TIME_NS / CLK_PERIOD_NS;
	localparam int          THERM_WAIT_US  = 1000;      // hold time at thermal point
	localparam int          THERM_WAIT_CYC = THERM_WAIT_US * 1000 / CLK_PERIOD_NS;
	localparam int          VC_W           = 6;         // supply voltage code width
	localparam int          MULT_W         = 5;         // core clock multiplier width
	localparam int          VC_MV_MAX      = 1708;      // millivolts at code zero
	localparam int          VC_MV_STEP     = 16;        // millivolts per code increment
	localparam int          AW             = 12;        // apb address width
	localparam logic [11:0] OFS_TARGET     = 12'h000;   // software target point
	localparam logic [11:0] OFS_THERM      = 12'h004;   // thermal fallback point
	localparam logic [11:0] OFS_STATUS     = 12'h008;   // current point and flags
	localparam logic [11:0] OFS_VOLT       = 12'h00c;   // requested supply in mV
	localparam int          F_VC_LSB       = 0;         // code field position
	localparam int          F_MULT_LSB     = 8;         // multiplier field position
	localparam int          F_BUSY         = 16;        // transition in progress
	localparam int          F_PEND         = 17;        // request deferred
	localparam int          F_THACT        = 18;        // thermal point in force
	localparam int          F_NRDY_SEEN    = 19;        // bus not ready wire low
	localparam logic [5:0]  RST_VC         = 6'h20;     // code after reset
	localparam logic [4:0]  RST_MULT       = 5'h06;     // multiplier after reset
	localparam logic [5:0]  RST_TH_VC      = 6'h30;     // thermal code after reset
	localparam logic [4:0]  RST_TH_MULT    = 5'h04;     // thermal multiplier after reset
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,   // no transition
		ST_VPRE  = 2'b01,   // stepping code before relock
		ST_LOCK  = 2'b11,   // relocking, core unavailable
		ST_VPOST = 2'b10    // stepping code after relock
	} dvfstc_state_e;
endpackage

// ==== design/dvfstc_top.sv ====
// operating-point transition controller with apb registers and bus pin control
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module dvfstc_top #(
	parameter int THERM_WAIT = dvfstc_pkg::THERM_WAIT_CYC  // thermal hold in cycles
) (
	input  wire logic                           CLK_I,                        // bus clock
	input  wire logic                           RST_I,                        // sync reset
	input  wire logic                           PSEL_I,                       // apb select
	input  wire logic                           PENABLE_I,                    // apb enable
	input  wire logic                           PWRITE_I,                     // apb write
	input  wire logic [dvfstc_pkg::AW-1:0]      PADDR_I,                      // apb address
	input  wire logic [31:0]                    PWDATA_I,                     // apb wdata
	output logic      [31:0]                    PRDATA_O,                     // apb rdata
	output logic                                PREADY_O,                     // apb ready
	output logic                                PSLVERR_O,                    // apb error
	input  wire logic                           THERM_HOT_I,                  // sensor, async
	input  wire logic                           SLEEP_I,                      // in sleep
	input  wire logic                           DEEP_SLEEP_REQUEST_N_I,       // async, low
	input  wire logic                           DATA_BUFFER_POWER_N_I,        // bus, low
	input  wire logic                           PRIORITY_AGENT_REQUEST_N_I,   // bus, low
	input  wire logic                           BUS_NOT_READY_N_I,            // wire level
	output logic                                BUS_NOT_READY_N_O,            // pin data
	output logic                                BUS_NOT_READY_N_OE_O,         // pin drive
	output logic                                BUS_NOT_READY_ODT_EN_O,       // termination
	output logic      [dvfstc_pkg::VC_W-1:0]    SUPPLY_VOLTAGE_CODE_O,        // to regulator
	output logic      [dvfstc_pkg::MULT_W-1:0]  CORE_MULT_O,                  // to core pll
	output logic                                CORE_STALL_O,                 // core unavailable
	output logic                                DATA_BUF_EN_O,                // data buffers on
	output logic                                ADDR_BUF_EN_O,                // addr buffers on
	output logic                                POWER_STATUS_N_O,             // deep sleep, low
	output logic                                THERM_EVENT_O                 // thermal pulse
);
	import dvfstc_pkg::*;

	// async inputs: bit 1 thermal, bit 0 deep sleep request (low active)
	logic [1:0]          s1_r, s2_r, s3_r, flt_r;      // synchroniser chain and filtered level
	logic [1:0]          s1_nxt, s2_nxt, s3_nxt, flt_nxt;
	dvfstc_state_e       state_r, state_nxt;            // sequencer state
	logic [VC_W-1:0]     vc_r, vc_nxt;                  // driven supply code
	logic [MULT_W-1:0]   mult_r, mult_nxt;              // driven multiplier
	logic [VC_W-1:0]     tgt_vc_r, tgt_vc_nxt;          // code of transition in flight
	logic [MULT_W-1:0]   tgt_mult_r, tgt_mult_nxt;      // multiplier in flight
	logic                up_r, up_nxt;                  // transition raises frequency
	logic [15:0]         cnt_r, cnt_nxt;                // step and lock timer
	logic                pend_r, pend_nxt;              // deferred software request
	logic [VC_W-1:0]     pend_vc_r, pend_vc_nxt;        // deferred code
	logic [MULT_W-1:0]   pend_mult_r, pend_mult_nxt;    // deferred multiplier
	logic [VC_W-1:0]     th_vc_r, th_vc_nxt;            // thermal fallback code
	logic [MULT_W-1:0]   th_mult_r, th_mult_nxt;        // thermal fallback multiplier
	logic [VC_W-1:0]     ret_vc_r, ret_vc_nxt;          // point to restore after cooling
	logic [MULT_W-1:0]   ret_mult_r, ret_mult_nxt;
	logic                th_act_r, th_act_nxt;          // thermal point in force
	logic [23:0]         wait_r, wait_nxt;              // thermal hold timer
	logic                evt_r, evt_nxt;                // thermal event pulse
	logic                deep_r, deep_nxt;              // deep sleep flag
	logic                stall_r, stall_nxt;            // driving bus not ready low
	logic                dbuf_r, dbuf_nxt;              // data buffer enable
	logic                abuf_r, abuf_nxt;              // address buffer enable
	logic [31:0]         rd_r, rd_nxt;                  // read data register
	logic [31:0]         rd_mux;                        // decoded read value
	logic                hit;                           // address is mapped
	logic                wr_acc;                        // write access phase
	logic                start;                         // transition begins
	logic [VC_W-1:0]     go_vc;                         // point being started
	logic [MULT_W-1:0]   go_mult;
	logic [15:0]         volt_mv;                       // requested supply in mV
	logic                hot, dslp_n;                   // filtered async levels

	assign hot    = flt_r[1];
	assign dslp_n = flt_r[0];

	// the filter only moves when stages two and three agree, so a glitch
	// shorter than two cycles never reaches the sequencer
	always_comb begin
		s1_nxt  = {THERM_HOT_I, DEEP_SLEEP_REQUEST_N_I};
		s2_nxt  = s1_r;
		s3_nxt  = s2_r;
		flt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
	end

	// synchroniser registers; deep sleep request idles high
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			s1_r  <= 2'h1;
			s2_r  <= 2'h1;
			s3_r  <= 2'h1;
			flt_r <= 2'h1;
		end else begin
			s1_r  <= s1_nxt;
			s2_r  <= s2_nxt;
			s3_r  <= s3_nxt;
			flt_r <= flt_nxt;
		end
	end

	// register decode; zero wait states, so pready is tied high
	assign wr_acc    = PSEL_I & PENABLE_I & PWRITE_I;
	assign hit       = (PADDR_I == OFS_TARGET) | (PADDR_I == OFS_THERM) |
	                   (PADDR_I == OFS_STATUS) | (PADDR_I == OFS_VOLT);
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;   // unmapped address only
	assign volt_mv   = 16'(VC_MV_MAX) - 16'(vc_r) * 16'(VC_MV_STEP);  // see R17

	// read value, captured in the setup cycle so prdata comes from a flop
	always_comb begin
		rd_mux = 32'h0;
		case (PADDR_I)
			OFS_TARGET: begin
				rd_mux[F_VC_LSB +: VC_W]     = pend_vc_r;
				rd_mux[F_MULT_LSB +: MULT_W] = pend_mult_r;
			end
			OFS_THERM: begin
				rd_mux[F_VC_LSB +: VC_W]     = th_vc_r;
				rd_mux[F_MULT_LSB +: MULT_W] = th_mult_r;
			end
			OFS_STATUS: begin
				rd_mux[F_VC_LSB +: VC_W]     = vc_r;
				rd_mux[F_MULT_LSB +: MULT_W] = mult_r;
				rd_mux[F_BUSY]               = (state_r != ST_IDLE);  // see R20
				rd_mux[F_PEND]               = pend_r;
				rd_mux[F_THACT]              = th_act_r;
				rd_mux[F_NRDY_SEEN]          = ~BUS_NOT_READY_N_I;
			end
			OFS_VOLT: rd_mux[15:0] = volt_mv;
			default:  rd_mux = 32'h0;   // unmapped reads as zero
		endcase
	end

	// sequencer, thermal handling, registers and pin controls
	always_comb begin
		state_nxt     = state_r;
		vc_nxt        = vc_r;
		mult_nxt      = mult_r;
		tgt_vc_nxt    = tgt_vc_r;
		tgt_mult_nxt  = tgt_mult_r;
		up_nxt        = up_r;
		cnt_nxt       = cnt_r;
		pend_nxt      = pend_r;
		pend_vc_nxt   = pend_vc_r;
		pend_mult_nxt = pend_mult_r;
		th_vc_nxt     = th_vc_r;
		th_mult_nxt   = th_mult_r;
		ret_vc_nxt    = ret_vc_r;
		ret_mult_nxt  = ret_mult_r;
		th_act_nxt    = th_act_r;
		wait_nxt      = wait_r;
		evt_nxt       = 1'b0;
		rd_nxt        = rd_r;
		start         = 1'b0;
		go_vc         = pend_vc_r;
		go_mult       = pend_mult_r;
		if (PSEL_I & ~PENABLE_I & ~PWRITE_I) begin
			rd_nxt = rd_mux;
		end
		// hold timer only runs while parked at the thermal point
		if (th_act_r & (state_r == ST_IDLE)) begin
			wait_nxt = (wait_r == 24'(THERM_WAIT - 1)) ? 24'h0 : wait_r + 24'h1;
		end
		case (state_r)
			ST_IDLE: begin
				if (hot & ~th_act_r) begin   // see R21
					start        = 1'b1;   // see R9
					go_vc        = th_vc_r;
					go_mult      = th_mult_r;
					ret_vc_nxt   = vc_r;
					ret_mult_nxt = mult_r;
					th_act_nxt   = 1'b1;
					wait_nxt     = 24'h0;
					evt_nxt      = 1'b1;   // see R11
				end else if (th_act_r & ~hot & (wait_r == 24'(THERM_WAIT - 1))) begin
					start      = 1'b1;     // see R10
					go_vc      = ret_vc_r;
					go_mult    = ret_mult_r;
					th_act_nxt = 1'b0;
					evt_nxt    = 1'b1;     // see R11
				end else if (pend_r & ~th_act_r) begin
					start    = 1'b1;       // see R4
					pend_nxt = 1'b0;
				end
				if (start) begin
					tgt_vc_nxt   = go_vc;
					tgt_mult_nxt = go_mult;
					up_nxt       = (go_mult > mult_r);
					cnt_nxt      = 16'h0;
					if (go_mult > mult_r) begin
						state_nxt = ST_VPRE;   // see R2
					end else if (go_mult < mult_r) begin
						state_nxt = ST_LOCK;   // see R3
						mult_nxt  = go_mult;   // see R18
					end else begin
						state_nxt = ST_VPOST;
					end
				end
			end
			ST_VPRE, ST_VPOST: begin
				if (vc_r == tgt_vc_r) begin
					cnt_nxt = 16'h0;
					if (state_r == ST_VPRE) begin
						state_nxt = ST_LOCK;     // see R2
						mult_nxt  = tgt_mult_r;  // see R18
					end else begin
						state_nxt = ST_IDLE;
					end
				end else if (cnt_r == 16'(STEP_CYC - 1)) begin
					cnt_nxt = 16'h0;
					// one code at a time so the regulator ramps cleanly
					vc_nxt  = (vc_r > tgt_vc_r) ? vc_r - 6'h1 : vc_r + 6'h1;  // see R5
				end else begin
					cnt_nxt = cnt_r + 16'h1;
				end
			end
			ST_LOCK: begin
				if (cnt_r == 16'(LOCK_CYC - 1)) begin   // see R6
					cnt_nxt   = 16'h0;
					state_nxt = up_r ? ST_IDLE : ST_VPOST;  // see R3
				end else begin
					cnt_nxt = cnt_r + 16'h1;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		// writes come last so a new request outlives a same-cycle dispatch
		if (wr_acc & (PADDR_I == OFS_TARGET)) begin
			pend_nxt      = 1'b1;      // see R1
			pend_vc_nxt   = PWDATA_I[F_VC_LSB +: VC_W];     // see R20
			pend_mult_nxt = PWDATA_I[F_MULT_LSB +: MULT_W];
		end
		if (wr_acc & (PADDR_I == OFS_THERM)) begin
			th_vc_nxt   = PWDATA_I[F_VC_LSB +: VC_W];
			th_mult_nxt = PWDATA_I[F_MULT_LSB +: MULT_W];
		end
		// deep sleep is only honoured from sleep; release follows the request pin
		deep_nxt  = ~dslp_n & (SLEEP_I | deep_r);       // see R15
		stall_nxt = (state_nxt == ST_LOCK);             // see R7
		dbuf_nxt  = ~DATA_BUFFER_POWER_N_I;             // see R12
		abuf_nxt  = ~PRIORITY_AGENT_REQUEST_N_I;        // see R13
	end

	// state registers
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state_r     <= ST_IDLE;
			vc_r        <= RST_VC;
			mult_r      <= RST_MULT;
			tgt_vc_r    <= RST_VC;
			tgt_mult_r  <= RST_MULT;
			up_r        <= 1'b0;
			cnt_r       <= 16'h0;
			pend_r      <= 1'b0;
			pend_vc_r   <= RST_VC;
			pend_mult_r <= RST_MULT;
			th_vc_r     <= RST_TH_VC;
			th_mult_r   <= RST_TH_MULT;
			ret_vc_r    <= RST_VC;
			ret_mult_r  <= RST_MULT;
			th_act_r    <= 1'b0;
			wait_r      <= 24'h0;
			evt_r       <= 1'b0;
			deep_r      <= 1'b0;
			stall_r     <= 1'b0;
			dbuf_r      <= 1'b0;
			abuf_r      <= 1'b0;
			rd_r        <= 32'h0;
		end else begin
			state_r     <= state_nxt;
			vc_r        <= vc_nxt;
			mult_r      <= mult_nxt;
			tgt_vc_r    <= tgt_vc_nxt;
			tgt_mult_r  <= tgt_mult_nxt;
			up_r        <= up_nxt;
			cnt_r       <= cnt_nxt;
			pend_r      <= pend_nxt;
			pend_vc_r   <= pend_vc_nxt;
			pend_mult_r <= pend_mult_nxt;
			th_vc_r     <= th_vc_nxt;
			th_mult_r   <= th_mult_nxt;
			ret_vc_r    <= ret_vc_nxt;
			ret_mult_r  <= ret_mult_nxt;
			th_act_r    <= th_act_nxt;
			wait_r      <= wait_nxt;
			evt_r       <= evt_nxt;
			deep_r      <= deep_nxt;
			stall_r     <= stall_nxt;
			dbuf_r      <= dbuf_nxt;
			abuf_r      <= abuf_nxt;
			rd_r        <= rd_nxt;
		end
	end

	// outputs; the pin is open drain, so only the enable ever moves
	assign PRDATA_O               = rd_r;
	assign SUPPLY_VOLTAGE_CODE_O  = vc_r;      // see R16
	assign CORE_MULT_O            = mult_r;
	assign CORE_STALL_O           = stall_r;
	assign BUS_NOT_READY_N_O      = 1'b0;
	assign BUS_NOT_READY_N_OE_O   = stall_r;   // see R7
	assign BUS_NOT_READY_ODT_EN_O = ~stall_r;  // see R14
	assign DATA_BUF_EN_O          = dbuf_r;
	assign ADDR_BUF_EN_O          = abuf_r;
	assign POWER_STATUS_N_O       = ~deep_r;   // see R15
	assign THERM_EVENT_O          = evt_r;
	// helper: length of the current unavailable stretch
	logic [15:0] run_r;
	always_ff @(posedge CLK_I) begin
		run_r <= (RST_I | ~stall_r) ? 16'h0 : run_r + 16'h1;
	end
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	// the counter reaches the full lock length in the cycle after the stall drops
	a_stall_bound: assert property (CORE_STALL_O |-> run_r < 16'(LOCK_CYC)) // see R6
		else $error("core unavailable too long");
	a_nrdy_stall: assert property ((state_r == ST_LOCK) == BUS_NOT_READY_N_OE_O) // see R7
		else $error("bus not ready not tied to relock");
	a_up_volt_first: assert property ((state_r == ST_LOCK && up_r) |-> vc_r == tgt_vc_r) // see R2
		else $error("relock before voltage raised");
	a_down_lock_first: assert property ((state_r == ST_VPOST) |-> mult_r == tgt_mult_r) // see R3
		else $error("voltage moved before relock");
	a_code_one_step: assert property ($changed(vc_r) |->
		(vc_r == $past(vc_r) + 6'h1 || vc_r == $past(vc_r) - 6'h1) ##1 $stable(vc_r)[*8]) // see R5
		else $error("voltage code jumped or paced too fast");
	a_write_starts: assert property ((wr_acc && PADDR_I == OFS_TARGET) |=> pend_r) // see R1
		else $error("target write lost");
	a_pend_waits: assert property ((pend_r && state_r != ST_IDLE) |=> pend_r) // see R4
		else $error("deferred request dropped");
	a_therm_pulse: assert property (THERM_EVENT_O |-> $changed(th_act_r) ##1 !THERM_EVENT_O) // see R11
		else $error("thermal event not tied to transition");
	a_therm_prio: assert property ((state_r == ST_IDLE && hot && !th_act_r && pend_r) |=>
		(pend_r && tgt_vc_r == $past(th_vc_r))) // see R21
		else $error("thermal down not first");
	a_data_buf: assert property (DATA_BUF_EN_O == !$past(DATA_BUFFER_POWER_N_I)) // see R12
		else $error("data buffer enable wrong");
	a_addr_buf: assert property (ADDR_BUF_EN_O == !$past(PRIORITY_AGENT_REQUEST_N_I)) // see R13
		else $error("address buffer enable wrong");
	a_odt_off: assert property (BUS_NOT_READY_N_OE_O |-> !BUS_NOT_READY_ODT_EN_O) // see R14
		else $error("termination on while driving low");
	a_deep_status: assert property ((!dslp_n && SLEEP_I) |=> !POWER_STATUS_N_O) // see R15
		else $error("power status missing in deep sleep");
endmodule

// ==== tb/dvfstc_vr_model.sv ====
// regulator and bus agent model facing the transition controller
`timescale 1ns/100ps
module dvfstc_vr_model (
	input  wire logic       clk_i,     // bus clock
	input  wire logic       rst_i,     // sync reset
	input  wire logic [5:0] code_i,    // requested supply code
	input  wire logic       drv_i,     // not ready pin data
	input  wire logic       oe_i,      // not ready pin drive
	output logic            wire_o,    // not ready wire level
	output logic            data_buffer_power_n_n_o,  // data activity coming, low
	output logic            priority_agent_request_n_n_o,  // priority request, low
	output int              mv_o       // regulated supply in mV
);
	logic [4:0] cnt;  // activity pattern counter
	// pull-up holds the wire high whenever nobody drives it
	assign wire_o = oe_i ? drv_i : 1'b1;
	// linear table; a wrong step size would show up in the volt readback
	assign mv_o = 1708 - 16 * int'(code_i);
	// chipset announces data and priority traffic in short bursts, never cache flush;
	// both requests stay idle while reset is held
	always @(posedge clk_i) begin
		cnt      <= rst_i ? 5'h00 : cnt + 5'h01;
		data_buffer_power_n_n_o <= rst_i | (cnt[3:1] != 3'h2);
		priority_agent_request_n_n_o <= rst_i | (cnt[4:2] != 3'h5);
	end
endmodule

// ==== tb/dvfs_transition_controller_tb_top.sv ====
// self-checking bench for the operating-point transition controller
`timescale 1ns/100ps
module dvfs_transition_controller_tb_top;
	import dvfstc_pkg::*;
	logic              clk, rst, psel, pen, pwr, hot, slp, dsr, data_buffer_power_n_n, priority_agent_request_n_n, bnr_w;
	logic [AW-1:0]     padr;
	logic [31:0]       pwd, prd, q;
	logic              pready, perr, qerr, bnr_d, bnr_oe, odt, stall, dbuf, abuf, psi_n, tev;
	logic [VC_W-1:0]   code;
	logic [VC_W-1:0]   lastc = RST_VC;  // last code seen, for pacing
	logic [MULT_W-1:0] mult;
	logic              prev_d, prev_a, prev_e;
	logic [1:0]        up;  // monitor armed two edges after reset
	int                mv, error_cnt = 0, checks = 0, gap = 40, len = 0, run = 0, evn = 0;

	dvfstc_top #(.THERM_WAIT(50)) i_dvfstc_top (
		.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
		.THERM_HOT_I(hot), .SLEEP_I(slp), .DEEP_SLEEP_REQUEST_N_I(dsr),
		.DATA_BUFFER_POWER_N_I(data_buffer_power_n_n), .PRIORITY_AGENT_REQUEST_N_I(priority_agent_request_n_n),
		.BUS_NOT_READY_N_I(bnr_w), .BUS_NOT_READY_N_O(bnr_d), .BUS_NOT_READY_N_OE_O(bnr_oe),
		.BUS_NOT_READY_ODT_EN_O(odt), .SUPPLY_VOLTAGE_CODE_O(code), .CORE_MULT_O(mult),
		.CORE_STALL_O(stall), .DATA_BUF_EN_O(dbuf), .ADDR_BUF_EN_O(abuf),
		.POWER_STATUS_N_O(psi_n), .THERM_EVENT_O(tev));
	dvfstc_vr_model i_dvfstc_vr_model (.clk_i(clk), .rst_i(rst), .code_i(code), .drv_i(bnr_d),
		.oe_i(bnr_oe), .wire_o(bnr_w), .data_buffer_power_n_n_o(data_buffer_power_n_n), .priority_agent_request_n_n_o(priority_agent_request_n_n), .mv_o(mv));

	// free-running bus clock, 25 ns
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one apb transfer; holds the request until pready is sampled high
	task automatic acc(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr  <= w;
		padr <= a;
		pwd  <= d;
		@(posedge clk);
		pen  <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q    = prd;
		qerr = perr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask
	task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// poll status until neither busy nor pending; watchdog cuts a hang
	task automatic wait_idle;
		do acc(1'b0, OFS_STATUS, 32'h0); while ((q[F_BUSY] | q[F_PEND]) !== 1'b0);
	endtask
	task automatic wait_stall(input logic v);
		do @(negedge clk); while (stall !== v);
	endtask

	// pin monitor: buffer control, termination, stall, pacing, event width
	always @(posedge clk) begin
		up <= rst ? 2'b00 : {up[0], 1'b1};
		if (up[1] === 1'b1) begin
			chk(32'(dbuf), 32'(!prev_d));
			chk(32'(abuf), 32'(!prev_a));
			chk(32'(odt), 32'(!bnr_oe));
			chk(32'(stall), 32'(bnr_oe & !bnr_w));
			chk(32'(tev & prev_e), 32'h0);
			if (code !== lastc) begin
				chk(32'(gap >= STEP_CYC - 1), 32'h1);
				chk(32'(code - lastc == 6'h01 || lastc - code == 6'h01), 32'h1);
				gap = 0;
				lastc = code;
			end else gap++;
			if (stall === 1'b1) len++;
			else if (len > 0) begin
				chk(len, 400);
				run++;
				len = 0;
			end
			if (tev === 1'b1) evn++;
		end
		prev_d = data_buffer_power_n_n;
		prev_a = priority_agent_request_n_n;
		prev_e = tev;
	end
	// hang guard, far beyond the expected few thousand cycles
	initial begin
		#500000;
		error_cnt++;
		close_out;
	end
	initial begin
		{psel, pen, pwr, hot, slp, padr, pwd} = '0;
		dsr = 1'b1;
		rst = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// reset values, read-only and unmapped places
		rd(OFS_STATUS, 32'h0000_0620);
		rd(OFS_THERM, 32'h0000_0430);
		rd(OFS_VOLT, 32'h0000_04ac);
		acc(1'b1, OFS_STATUS, 32'hffff_ffff);
		acc(1'b1, 12'h010, 32'h0000_0101);
		chk(32'(qerr), 32'h1);
		rd(12'h010, 32'h0);
		rd(OFS_STATUS, 32'h0000_0620);
		$display("test registers done");
		// faster point, then two deferred requests where the newest wins
		acc(1'b1, OFS_TARGET, 32'h0000_081e);
		acc(1'b1, OFS_TARGET, 32'h0000_0722);
		acc(1'b1, OFS_TARGET, 32'h0000_0424);
		acc(1'b0, OFS_STATUS, 32'h0);
		chk(32'(q[F_BUSY] & q[F_PEND]), 32'h1);
		rd(OFS_TARGET, 32'h0000_0424);
		wait_stall(1'b1);
		chk({code, mult}, {6'h1e, 5'h08});
		wait_stall(1'b0);
		wait_stall(1'b1);
		chk({code, mult}, {6'h1e, 5'h04});
		wait_idle;
		rd(OFS_STATUS, 32'h0000_0424);
		acc(1'b0, OFS_VOLT, 32'h0);
		chk(q, 32'(mv));
		$display("test software transitions done");
		// thermal fallback with a software request parked behind it
		acc(1'b1, OFS_THERM, 32'h0000_0328);
		hot <= 1'b1;
		do @(negedge clk); while (evn < 1);
		wait_idle;
		rd(OFS_STATUS, 32'h0004_0328);
		acc(1'b1, OFS_TARGET, 32'h0000_0520);
		rd(OFS_STATUS, 32'h0006_0328);
		hot <= 1'b0;
		do @(negedge clk); while (evn < 2);
		chk({code, mult}, {6'h28, 5'h03});
		wait_idle;
		rd(OFS_STATUS, 32'h0000_0520);
		chk(run, 5);
		$display("test thermal done");
		// thermal event during a transition with a request parked: thermal goes first
		acc(1'b1, OFS_TARGET, 32'h0000_0624);
		acc(1'b1, OFS_TARGET, 32'h0000_0522);
		hot <= 1'b1;
		do @(negedge clk); while (evn < 3);
		rd(OFS_STATUS, 32'h000f_0324);
		hot <= 1'b0;
		do @(negedge clk); while (evn < 4);
		wait_idle;
		rd(OFS_STATUS, 32'h0000_0522);
		chk(run, 9);
		chk(evn, 4);
		$display("test thermal priority done");
		// deep sleep is requested only from ordinary sleep; sleep alone keeps status high
		slp <= 1'b1;
		repeat (8) @(negedge clk);
		chk(32'(psi_n), 32'h1);
		@(posedge clk);
		dsr <= 1'b0;
		repeat (8) @(negedge clk);
		chk(32'(psi_n), 32'h0);
		@(posedge clk);
		dsr <= 1'b1;
		repeat (8) @(negedge clk);
		chk(32'(psi_n), 32'h1);
		@(posedge clk);
		slp <= 1'b0;
		$display("test deep sleep done");
		close_out;
	end
endmodule
